// ---- iaf_consts.vh ----
// constants for the input assembly framer: layouts, apb map, reset values
// assumes apb slave with 32-bit data, one word per register
// How it works
// - basic frame length is five plus result
// - layout 101 length one to 264
// - layout 101 user data from byte 9
// - layout 101 fragment bytes at 2,3,4
// - layout 101 result length low 7, high 8
// - layout 102 length one to 265
// - layout 102 user data from byte 10
// - layout 100 length up to 260
// - frames sent cyclically, status byte first
`ifndef IAF_CONSTS_VH
`define IAF_CONSTS_VH
`define IAF_INST_BASIC   8'd100
`define IAF_INST_EXT1    8'd101
`define IAF_INST_EXT2    8'd102
`define IAF_HDR_BASIC    9'd5
`define IAF_HDR_EXT1     9'd9
`define IAF_HDR_EXT2     9'd10
`define IAF_MAX_BASIC    9'd260
`define IAF_MAX_EXT1     9'd264
`define IAF_MAX_EXT2     9'd265
`define IAF_MIN_LEN      9'd1
`define IAF_REG_CTRL     12'h000
`define IAF_REG_FRAG     12'h004
`define IAF_REG_RES      12'h008
`define IAF_REG_EVT      12'h00c
`define IAF_REG_STAT     12'h010
`define IAF_REG_SW       12'h014
`define IAF_CTRL_RST     32'h0000_0000
`define IAF_FIFO_DEPTH   32
`endif

// ---- iaf_fifo.v ----
// iaf_fifo: synchronous fifo with valid/ready on both sides
// assumes one clock; clock enable freezes all state
`timescale 1ns/1ps
module iaf_fifo #(
   parameter W = 8,
   parameter D = 32,
   parameter AW = 5
) (
   // clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire         ce_i,
   // write side
   input  wire [W-1:0] wdata_i,
   input  wire         wvalid_i,
   output wire         wready_o,
   // read side
   output wire [W-1:0] rdata_o,
   output wire         rvalid_o,
   input  wire         rready_i,
   // level
   output wire [AW:0]  count_o
);
   reg [W-1:0] mem [0:D-1];
   reg [AW:0]  wp_q;
   reg [AW:0]  rp_q;
   wire        wr = wvalid_i & wready_o & ce_i;
   wire        rd = rvalid_o & rready_i & ce_i;
   assign count_o  = wp_q - rp_q;
   assign wready_o = (count_o != D[AW:0]);
   assign rvalid_o = (count_o != {(AW+1){1'b0}});
   assign rdata_o  = mem[rp_q[AW-1:0]];
   always @(posedge clk_i) begin
      if (wr) begin
         mem[wp_q[AW-1:0]] <= wdata_i;
      end
   end
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_q <= {(AW+1){1'b0}};
         rp_q <= {(AW+1){1'b0}};
      end else begin
         if (wr) begin
            wp_q <= wp_q + 1'b1;
         end
         if (rd) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule

// ---- iaf_framer.v ----
// iaf_framer: builds cyclic input assembly frames as a byte stream
// assumes apb master for config/status, result bytes pushed on a byte stream
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`include "iaf_consts.vh"
module iaf_framer #(
   parameter DEPTH = `IAF_FIFO_DEPTH,
   parameter AW    = 5
) (
   // clock, reset, enable
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   // apb slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   // result data in
   input  wire [7:0]  res_data_i,
   input  wire        res_valid_i,
   output wire        res_ready_o,
   // event pulses and switch state levels
   input  wire        ev_accept_i,
   input  wire        ev_reject_i,
   input  wire        ev_new_result_i,
   input  wire [1:0]  sw_cmp_ev_i,
   input  wire [1:0]  sw_io_i,
   input  wire [1:0]  sw_cmp_i,
   // frame out
   output reg  [7:0]  frm_data_o,
   output wire        frm_valid_o,
   output wire        frm_sof_o,
   output wire        frm_eof_o,
   input  wire        frm_ready_i
);
   localparam S_IDLE = 2'd0;
   localparam S_SEND = 2'd1;
   // control: [0] enable, [2:1] layout sel, [17:9] configured length
   reg  [31:0] ctrl_q;
   reg  [31:0] frag_q;   // [7:0] number, [15:8] remaining, [23:16] size
   reg  [31:0] res_q;    // [7:0] count, [15:8] flags, [31:16] length
   reg  [7:0]  stat_q;   // device status, [12:10] error code in evt
   reg  [2:0]  err_q;
   reg         tg_acc_q;
   reg         tg_rej_q;
   reg         tg_new_q;
   reg  [1:0]  tg_sw_q;
   reg  [1:0]  st_q;
   reg  [8:0]  idx_q;
   reg  [31:0] frames_q;
   reg  [7:0]  hb;
   wire [1:0]  lay  = ctrl_q[2:1];
   wire [8:0]  clen = ctrl_q[17:9];
   wire [8:0]  hdr  = (lay == 2'd2) ? `IAF_HDR_EXT2 : (lay == 2'd1) ? `IAF_HDR_EXT1 : `IAF_HDR_BASIC;
   wire [8:0]  lmax = (lay == 2'd2) ? `IAF_MAX_EXT2 : (lay == 2'd1) ? `IAF_MAX_EXT1 : `IAF_MAX_BASIC;
   // out-of-range length falls back to the minimum of one byte
   wire [8:0]  flen = (clen < `IAF_MIN_LEN || clen > lmax) ? `IAF_MIN_LEN : clen;
   wire [7:0]  fifo_q;
   wire        fifo_v;
   wire        in_data = (idx_q >= hdr);
   wire        fifo_rd = (st_q == S_SEND) && in_data && frm_ready_i && ce_i;
   // apb: zero-wait answer, unmapped reads zero with error
   wire        acc  = psel_i & penable_i & ce_i;
   wire        wr   = acc & pwrite_i;
   reg         hit;
   reg  [31:0] rdat_d;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;
   // read mux feeds a flop loaded in the setup cycle, so read data is registered
   // and still answers with zero wait states
   always @* begin
      hit = 1'b1;
      rdat_d = 32'h0000_0000;
      if (paddr_i == `IAF_REG_CTRL) begin
         rdat_d = ctrl_q;
      end else if (paddr_i == `IAF_REG_FRAG) begin
         rdat_d = frag_q;
      end else if (paddr_i == `IAF_REG_RES) begin
         rdat_d = res_q;
      end else if (paddr_i == `IAF_REG_EVT) begin
         rdat_d = {19'h0, err_q, tg_sw_q, tg_new_q, tg_rej_q, tg_acc_q, 5'h0};
      end else if (paddr_i == `IAF_REG_STAT) begin
         rdat_d = {24'h0, stat_q};
      end else if (paddr_i == `IAF_REG_SW) begin
         rdat_d = frames_q;
      end else begin
         hit = 1'b0;
      end
   end
   // header byte mux per layout
   always @* begin
      hb = 8'h00;
      if (idx_q == 9'd0) begin
         hb = stat_q;
      end else if (lay == 2'd0) begin
         case (idx_q)
            9'd1: hb = res_q[7:0];
            // new-result toggle takes flag bit 4
            9'd2: hb = {2'b00, res_q[13], tg_new_q, res_q[11:8]};
            9'd3: hb = res_q[23:16];
            9'd4: hb = res_q[31:24];
            default: hb = 8'h00;
         endcase
      end else begin
         // second extended layout shifts everything by one switching byte
         case (idx_q - ((lay == 2'd2) ? 9'd1 : 9'd0))
            9'd1: hb = {1'b0, err_q, 2'b00, tg_rej_q, tg_acc_q};
            9'd2: hb = frag_q[7:0];
            9'd3: hb = frag_q[15:8];
            9'd4: hb = frag_q[23:16];
            9'd5: hb = res_q[7:0];
            9'd6: hb = {2'b00, res_q[13], tg_new_q, res_q[11:8]};
            9'd7: hb = res_q[23:16];
            9'd8: hb = res_q[31:24];
            default: hb = 8'h00;
         endcase
         if (lay == 2'd2 && idx_q == 9'd1) begin
            hb = {1'b0, tg_sw_q[1], sw_cmp_i[1], sw_io_i[1], 1'b0, tg_sw_q[0], sw_cmp_i[0], sw_io_i[0]};
         end
      end
   end
   assign frm_valid_o = (st_q == S_SEND) && (!in_data || fifo_v);
   assign frm_sof_o   = (st_q == S_SEND) && (idx_q == 9'd0);
   assign frm_eof_o   = (st_q == S_SEND) && (idx_q == flen - 9'd1);
   always @* begin
      frm_data_o = in_data ? fifo_q : hb;
   end
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q   <= `IAF_CTRL_RST;
         frag_q   <= 32'h0000_0000;
         res_q    <= 32'h0000_0000;
         stat_q   <= 8'h00;
         err_q    <= 3'h0;
         tg_acc_q <= 1'b0;
         tg_rej_q <= 1'b0;
         tg_new_q <= 1'b0;
         tg_sw_q  <= 2'b00;
         st_q     <= S_IDLE;
         idx_q    <= 9'd0;
         frames_q <= 32'h0000_0000;
         prdata_o <= 32'h0000_0000;
      end else if (ce_i) begin
         if (psel_i && !penable_i) begin
            prdata_o <= rdat_d;
         end
         if (wr && paddr_i == `IAF_REG_CTRL) begin
            ctrl_q <= {14'h0, pwdata_i[17:0]};
         end
         if (wr && paddr_i == `IAF_REG_FRAG) begin
            frag_q <= {8'h0, pwdata_i[23:0]};
         end
         if (wr && paddr_i == `IAF_REG_RES) begin
            res_q <= pwdata_i;
         end
         if (wr && paddr_i == `IAF_REG_EVT) begin
            err_q <= pwdata_i[12:10];
         end
         if (wr && paddr_i == `IAF_REG_STAT) begin
            stat_q <= pwdata_i[7:0];
         end
         // each event pulse flips its bit once
         if (ev_accept_i) begin
            tg_acc_q <= ~tg_acc_q;
         end
         if (ev_reject_i) begin
            tg_rej_q <= ~tg_rej_q;
         end
         if (ev_new_result_i) begin
            tg_new_q <= ~tg_new_q;
         end
         tg_sw_q <= tg_sw_q ^ sw_cmp_ev_i;
         case (st_q)
            S_IDLE: begin
               if (ctrl_q[0]) begin
                  st_q  <= S_SEND;
                  idx_q <= 9'd0;
               end
            end
            S_SEND: begin
               if (frm_valid_o && frm_ready_i) begin
                  if (frm_eof_o) begin
                     st_q     <= S_IDLE;
                     idx_q    <= 9'd0;
                     frames_q <= frames_q + 32'd1;
                  end else begin
                     idx_q <= idx_q + 9'd1;
                  end
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
   iaf_fifo #(.W(8), .D(DEPTH), .AW(AW)) u_fifo (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .wdata_i  (res_data_i),
      .wvalid_i (res_valid_i),
      .wready_o (res_ready_o),
      .rdata_o  (fifo_q),
      .rvalid_o (fifo_v),
      .rready_i (fifo_rd),
      .count_o  ()
   );
endmodule

// ---- iaf_framer_asserts.sv ----
// port checker for iaf_framer
// assumes one clock, async active-high reset
`timescale 1ns/1ps
module iaf_chk (
   // clock and reset
   input logic        clk_i,
   input logic        rst_i,
   // apb
   input logic        psel_i,
   input logic        penable_i,
   input logic [11:0] paddr_i,
   input logic        pready_o,
   input logic        pslverr_o,
   // streams
   input logic        res_ready_o,
   input logic [7:0]  frm_data_o,
   input logic        frm_valid_o,
   input logic        frm_sof_o,
   input logic        frm_eof_o,
   input logic        frm_ready_i
);
   logic [8:0] n_q;
   // bytes taken so far in the current frame
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         n_q <= 9'h0;
      else if (frm_valid_o && frm_ready_i)
         n_q <= frm_eof_o ? 9'h0 : n_q + 9'h1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_PREADY: assert property (psel_i && penable_i |-> pready_o)
      else $error("apb wait state seen");
   AST_SLVERR: assert property (psel_i && penable_i && paddr_i > 12'h014 |-> pslverr_o)
      else $error("unmapped access not flagged");
   AST_OKADDR: assert property (psel_i && penable_i && paddr_i <= 12'h014 && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
      else $error("mapped access flagged");
   AST_SOF_VALID: assert property (frm_sof_o |-> frm_valid_o)
      else $error("start without valid");
   AST_SOF_FIRST: assert property (frm_sof_o && frm_valid_o |-> n_q == 9'd0)
      else $error("start marked inside a frame");
   AST_HOLD: assert property (frm_valid_o && !frm_ready_i |=> frm_valid_o && $stable(frm_data_o))
      else $error("byte dropped while stalled");
   AST_EOF_IDLE: assert property (frm_valid_o && frm_ready_i && frm_eof_o |=> !frm_valid_o)
      else $error("no idle after frame");
   AST_SOF_NEXT: assert property (frm_valid_o && frm_ready_i && frm_eof_o ##2 frm_valid_o |-> frm_sof_o)
      else $error("next frame lacks start");
   AST_LEN: assert property (n_q < 9'd265)
      else $error("frame too long");
   AST_RST: assert property (disable iff (1'b0) rst_i |-> !frm_valid_o && res_ready_o)
      else $error("outputs active in reset");
endmodule
bind iaf_framer iaf_chk u_chk (.clk_i, .rst_i, .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o,
   .res_ready_o, .frm_data_o, .frm_valid_o, .frm_sof_o, .frm_eof_o, .frm_ready_i);

// ---- iaf_framer_tb_top.sv ----
// self-checking bench for iaf_framer
// assumes iaf_plc_sink consumes frames
`timescale 1ns/1ps
module iaf_framer_tb_top;
   logic        clk_i = 0, rst_i, psel_i = 0, penable_i = 0, pwrite_i = 0, slow = 0;
   logic [11:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o;
   logic        pready_o, pslverr_o, res_valid_i = 0, res_ready_o, ev_accept_i = 0;
   logic        ev_reject_i = 0, ev_new_result_i = 0, frm_valid_o, frm_sof_o, frm_eof_o, frm_ready_i;
   logic [7:0]  res_data_i = 0, frm_data_o;
   logic [1:0]  sw_cmp_ev_i = 0, sw_io_i = 2'h1, sw_cmp_i = 2'h2;
   logic        ce_i = 1;
   int          miscompares = 0, total_checks = 0;
   always #25 clk_i = ~clk_i;
   iaf_framer u_dut (.clk_i, .rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .res_data_i, .res_valid_i, .res_ready_o, .ev_accept_i,
      .ev_reject_i, .ev_new_result_i, .sw_cmp_ev_i, .sw_io_i, .sw_cmp_i, .frm_data_o,
      .frm_valid_o, .frm_sof_o, .frm_eof_o, .frm_ready_i);
   iaf_plc_sink u_sink (.clk_i, .rst_i, .slow_i(slow), .data_i(frm_data_o), .valid_i(frm_valid_o),
      .eof_i(frm_eof_o), .ready_o(frm_ready_i));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk_i);
      psel_i    <= 1;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clk_i);
      penable_i <= 1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i    <= 0;
      penable_i <= 0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1, a, d, r, e);
   endtask
   task automatic toggles;
      logic [31:0] a, b;
      logic        e;
      apb(0, 12'h00c, 0, a, e);
      ev_accept_i <= 1;
      @(posedge clk_i);
      ev_accept_i <= 0;
      apb(0, 12'h00c, 0, b, e);
      chk(b[7:5], a[7:5] ^ 3'h1);
      ev_reject_i     <= 1;
      ev_new_result_i <= 1;
      @(posedge clk_i);
      ev_reject_i     <= 0;
      ev_new_result_i <= 0;
      apb(0, 12'h00c, 0, a, e);
      chk(a[7:5], b[7:5] ^ 3'h6);
      apb(0, 12'h018, 0, a, e);
      chk(e, 1);
      chk(a, 0);
      // frozen block must ignore a write
      ce_i <= 0;
      wr(12'h010, 32'h0000_00a5);
      ce_i <= 1;
      apb(0, 12'h010, 0, a, e);
      chk(a, 0);
   endtask
   // fresh reset per frame: a repeating frame with data bytes would stall on empty data
   task automatic frame(input logic [1:0] lay, input logic [8:0] len, input int np, input logic sl);
      int          h;
      logic [31:0] r;
      logic        e;
      h = lay == 0 ? 5 : lay == 1 ? 9 : 10;
      rst_i <= 1;
      slow  <= sl;
      @(posedge clk_i);
      rst_i           <= 0;
      sw_cmp_ev_i     <= 2'h1;
      ev_accept_i     <= 1;
      ev_new_result_i <= 1;
      @(posedge clk_i);
      sw_cmp_ev_i     <= 2'h0;
      ev_accept_i     <= 0;
      ev_new_result_i <= 0;
      wr(12'h00c, 32'h0000_1400);
      wr(12'h004, 32'h0003_0201);
      wr(12'h008, 32'h0104_0001);
      wr(12'h010, 32'h0000_005a);
      for (int i = 0; i < np; i++) begin
         res_data_i  <= 8'h10 + 8'(i);
         res_valid_i <= 1;
         do @(posedge clk_i); while (res_ready_o !== 1'b1);
      end
      res_valid_i <= 0;
      @(posedge clk_i);
      if (np == 32) chk(res_ready_o, 0);
      wr(12'h000, {14'h0, len, 6'h0, lay, 1'b1});
      while (u_sink.frames_q == 0) @(posedge clk_i);
      chk(u_sink.len_q, len > h + 255 ? 1 : len);
      chk(u_sink.mem_q[0], 8'h5a);
      if (len <= h + 255) begin
         for (int i = h; i < len; i++) chk(u_sink.mem_q[i], 8'h10 + i - h);
         chk(u_sink.mem_q[h-2], 8'h04);
         chk(u_sink.mem_q[h-1], 8'h01);
         chk(u_sink.mem_q[h-4], 8'h01);
         chk(u_sink.mem_q[h-3], 8'h10);
         if (lay != 0) begin
            chk(u_sink.mem_q[h-7], 8'h01);
            chk(u_sink.mem_q[h-6], 8'h02);
            chk(u_sink.mem_q[h-5], 8'h03);
            chk(u_sink.mem_q[h-8], 8'h51);
         end
         if (lay == 2) chk(u_sink.mem_q[1], 8'h25);
         // the next frame stalls on empty data, so exactly one frame is done
         apb(0, 12'h014, 0, r, e);
         chk(r, 1);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      toggles;
      frame(0, 9'd7, 2, 0);
      frame(1, 9'd13, 4, 1);
      frame(2, 9'd14, 4, 0);
      frame(1, 9'd41, 32, 1);
      frame(1, 9'd265, 0, 0);
      end_of_test;
   end
   initial begin
      #2_000_000;
      miscompares++;
      end_of_test;
   end
endmodule

// ---- iaf_plc_sink.sv ----
// frame consumer standing in for the scanning controller
// assumes one clock; slow_i halves the acceptance rate
`timescale 1ns/1ps
module iaf_plc_sink (
   // clock and reset
   input  logic       clk_i,
   input  logic       rst_i,
   input  logic       slow_i,
   // frame stream
   input  logic [7:0] data_i,
   input  logic       valid_i,
   input  logic       eof_i,
   output logic       ready_o
);
   logic [7:0] mem_q [64];
   int         n_q;
   int         len_q;
   int         frames_q;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ready_o  <= 1'b0;
         n_q      <= 0;
         frames_q <= 0;
      end else begin
         ready_o <= slow_i ? !ready_o : 1'b1;
         if (valid_i && ready_o) begin
            mem_q[n_q[5:0]] <= data_i;
            n_q             <= n_q + 1;
            // keep first frame only; later ones with data bytes stall on empty data
            if (eof_i && frames_q == 0) begin
               len_q    <= n_q + 1;
               frames_q <= 1;
            end
         end
      end
   end
endmodule
